//--- rtl/pdc_pkg.sv
// Constants shared by the preset down counter block.
`default_nettype none
package pdc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ctrl_addr   = 8'h00;
    localparam logic [7:0] preset_addr = 8'h04;
    localparam logic [7:0] status_addr = 8'h08;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int ctrl_load_bit  = 0;
    localparam int ctrl_clear_bit = 1;
    localparam int ctrl_rise_bit  = 2;
    localparam int ctrl_fall_bit  = 3;
    localparam int ctrl_carry_bit = 4;
    localparam int ctrl_width     = 5;
    localparam logic [4:0] ctrl_reset = 5'h00;
    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int status_tc_bit  = 4;
    localparam int count_width    = 4;
    localparam logic [3:0] count_reset = 4'h0;
endpackage
`default_nettype wire

//--- rtl/pdc_counter.sv
// Preset down counter with an APB register port.
`default_nettype none
// Behaviour
// - The count is four bits, goes down by one in each cycle that has a qualifying clock event and is shown on buffered outputs.
// - While load is high the preset value is copied into the count continuously, whatever the clock bits do.
// - With load low and the falling clock bit low, a low-to-high change of the rising clock bit decrements.
// - With load low and the rising clock bit high, a high-to-low change of the falling clock bit decrements.
// - The terminal flag is high only while the count is zero and carry forward is high.
// - A high clear forces the count to zero at once, over load, clocks and everything else.
module pdc_counter #(
    parameter int width = pdc_pkg::count_width
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Counter outputs
    output logic      [width-1:0] count_outputs,
    output logic                  zero_terminal_flag
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [pdc_pkg::ctrl_width-1:0] ctrl;
    logic [pdc_pkg::ctrl_width-1:0] next_ctrl;
    logic [width-1:0]               preset_inputs;
    logic [width-1:0]               next_preset_inputs;
    logic [width-1:0]               next_count_outputs;
    logic                           next_zero_terminal_flag;
    logic [31:0]                    next_prdata;
    logic                           wr_en;
    logic                           rd_setup;
    logic                           load_level;
    logic                           master_clear;
    logic                           rise_clock_in;
    logic                           fall_clock_in;
    logic                           carry_forward_in;
    logic                           rise_event;
    logic                           fall_event;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == pdc_pkg::ctrl_addr) || (a == pdc_pkg::preset_addr)
                  || (a == pdc_pkg::status_addr);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // The slave never stalls; a write to status or an unmapped address is flagged.
    assign pready   = 1'b1;
    assign pslverr  = psel && penable
                   && (!addr_known(paddr) || (pwrite && paddr == pdc_pkg::status_addr));
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        next_ctrl          = ctrl;
        next_preset_inputs = preset_inputs;
        if (wr_en && paddr == pdc_pkg::ctrl_addr) begin
            next_ctrl = pwdata[pdc_pkg::ctrl_width-1:0];
        end
        if (wr_en && paddr == pdc_pkg::preset_addr) begin
            next_preset_inputs = pwdata[width-1:0];
        end
        next_prdata = prdata;
        if (rd_setup) begin
            case (paddr)
                pdc_pkg::ctrl_addr: begin
                    next_prdata = {{(32-pdc_pkg::ctrl_width){1'b0}}, ctrl};
                end
                pdc_pkg::preset_addr: begin
                    next_prdata = {{(32-width){1'b0}}, preset_inputs};
                end
                pdc_pkg::status_addr: begin
                    next_prdata = 32'h0000_0000;
                    next_prdata[width-1:0] = count_outputs;
                    next_prdata[pdc_pkg::status_tc_bit] = zero_terminal_flag;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // The counter sees the new control value in the same edge it is written, so
    // clear and load act without a further cycle of delay.
    assign load_level       = next_ctrl[pdc_pkg::ctrl_load_bit];
    assign master_clear     = next_ctrl[pdc_pkg::ctrl_clear_bit];
    assign rise_clock_in    = next_ctrl[pdc_pkg::ctrl_rise_bit];
    assign fall_clock_in    = next_ctrl[pdc_pkg::ctrl_fall_bit];
    assign carry_forward_in = next_ctrl[pdc_pkg::ctrl_carry_bit];
    assign rise_event = rise_clock_in && !ctrl[pdc_pkg::ctrl_rise_bit] && !fall_clock_in;
    assign fall_event = !fall_clock_in && ctrl[pdc_pkg::ctrl_fall_bit] && rise_clock_in;

    always_comb begin
        next_count_outputs = count_outputs;
        if (master_clear) begin
            next_count_outputs = '0;
        end else if (load_level) begin
            next_count_outputs = next_preset_inputs;
        end else if (rise_event || fall_event) begin
            next_count_outputs = count_outputs - 1'b1;
        end
        next_zero_terminal_flag = (next_count_outputs == '0) && carry_forward_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl               <= pdc_pkg::ctrl_reset;
            preset_inputs      <= '0;
            count_outputs      <= '0;
            zero_terminal_flag <= 1'b0;
            prdata             <= 32'h0000_0000;
        end else begin
            ctrl               <= next_ctrl;
            preset_inputs      <= next_preset_inputs;
            count_outputs      <= next_count_outputs;
            zero_terminal_flag <= next_zero_terminal_flag;
            prdata             <= next_prdata;
        end
    end
endmodule
`default_nettype wire

//--- verification/pdc_counter_asserts.sv
// Port assertions for the preset down counter.
`default_nettype none
module pdc_counter_asserts (
    input wire logic        pclk, presetn, psel, penable, pwrite, zero_terminal_flag,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  count_outputs
);
    // Shadow of the control levels, needed to tell a clock edge from a held level.
    logic [3:0] o;
    wire        w = psel && penable && pwrite;
    wire        c = w && paddr == 8'h00;
    wire        d = c && pwdata[3:0] == 4'h4;
    wire  [3:0] q = count_outputs;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) o <= '0;
        else if (c) o <= pwdata[3:0];
    hold_a: assert property (!w |=> $stable(q)) else $error("count moved");
    load_copy_a: assert property (w && paddr == 8'h04 && o[1:0] == 2'b01 |=>
        q == $past(pwdata[3:0])) else $error("load");
    rise_dec_a: assert property (d && !o[2] |=> q == $past(q) - 4'h1) else $error("rise");
    fall_dec_a: assert property (d && o[3] |=> q == $past(q) - 4'h1) else $error("fall");
    wrap_a: assert property (d && !o[2] && q == 4'h0 |=> q == 4'hf) else $error("wrap");
    flag_a: assert property (c |=> zero_terminal_flag == ($past(pwdata[4]) && q == 4'h0))
        else $error("flag");
    clear_a: assert property (c && pwdata[1] |=> q == 4'h0) else $error("clear");
    cover property (d);
    cover property (zero_terminal_flag);
    cover property (c && pwdata[1]);
endmodule
bind pdc_counter pdc_counter_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .zero_terminal_flag, .paddr, .pwdata, .count_outputs);
`default_nettype wire

//--- verification/pdc_apb_master.sv
// APB master standing for the software that drives the counter.
`default_nettype none
module pdc_apb_master (
    input wire logic   pclk, pready, pslverr,
    input wire logic [31:0] prdata,
    output logic       psel, penable, pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Read data and error response taken at the edge that completes a transfer.
    logic [31:0] rdata;
    logic        serr;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(logic [7:0] a, logic [31:0] d, logic w = 1'b1);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

//--- verification/pdc_counter_tb_top.sv
// Self-checking bench for the preset down counter.
`default_nettype none
module pdc_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pslverr;
    logic [3:0]  cnt;
    int          err_count = 0, checks = 0;
    always #50 pclk = ~pclk;
    pdc_apb_master m (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
        .pwdata);
    pdc_counter DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .count_outputs(cnt), .zero_terminal_flag(flag));
    task automatic cmp(string n, logic [31:0] x, logic [31:0] s);
        checks++;
        if (s !== x) $display("Error %s expected %h seen %h", n, x, s);
        err_count += int'(s !== x);
    endtask
    task automatic t_regs();
        m.xfer(8'h08, 32'h0, 1'b0);
        cmp("status", 32'h0000_000f, m.rdata);
        m.xfer(8'h00, 32'h0, 1'b0);
        cmp("ctrl", 32'h0000_0014, m.rdata);
        m.xfer(8'h08, 32'h3);
        cmp("status_write_err", 32'h0000_0001, {31'h0, m.serr});
        m.xfer(8'h04, 32'h9);
        m.xfer(8'h04, 32'h0, 1'b0);
        cmp("preset", 32'h0000_0009, m.rdata);
        m.xfer(8'h08, 32'h0, 1'b0);
        cmp("status_held", 32'h0000_000f, m.rdata);
    endtask
    task automatic wc(logic [4:0] c, logic [4:0] x);
        m.xfer(8'h00, {27'h0, c});
        #1 checks++;
        if ({flag, cnt} !== x) $display("Error flag_count expected %h seen %h", x, {flag, cnt});
        err_count += int'({flag, cnt} !== x);
    endtask
    task automatic t_load();
        m.xfer(8'h04, 32'h5);
        wc(5'h01, 5'h05);
        wc(5'h03, 5'h00);
        m.xfer(8'h04, 32'h2);
        wc(5'h01, 5'h02);
    endtask
    task automatic t_down();
        wc(5'h14, 5'h01);
        wc(5'h10, 5'h01);
        wc(5'h14, 5'h10);
        wc(5'h1c, 5'h10);
        wc(5'h14, 5'h0f);
    endtask
    task automatic finish_test();
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_load();
        t_down();
        t_regs();
        finish_test();
    end
    initial begin
        #100000 err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
